//--- core/sh_stream_pkg.sv
// shared constants and carrier types for the sync header stream framer
package sh_stream_pkg;

    // block and multiblock geometry
    localparam int unsigned PAYLOAD_BITS   = 64;             // scrambled bits per block
    localparam int unsigned MB_BLOCKS      = 32;             // blocks per multiblock
    localparam logic [4:0]  LAST_BLOCK     = 5'h1f;          // index of final block
    localparam logic [4:0]  FIRST_BLOCK    = 5'h00;          // index of first block

    // parity generator
    localparam logic [11:0] CRC_POLY       = 12'h987;        // generator, lowest term implicit
    localparam logic [11:0] CRC_RESET      = 12'h000;        // stage value before each multiblock

    // format select codes
    typedef enum logic [1:0] {
        FMT_CRC12 = 2'b00,                                   // parity words in stream
        FMT_FEC   = 2'b10                                    // external fec word in stream
    } format_e;

    // stream word layout
    localparam int unsigned EMB_END_POS    = 22;             // end of extended multiblock
    localparam logic [4:0]  PILOT_FIRST    = 5'h1b;          // first bit of end pilot
    localparam logic [4:0]  PILOT_VALUE    = 5'h10;          // stream bits 31..27
    localparam logic [31:0] CRC_ONES_MASK  = 32'h80a88888;   // fixed ones, crc format
    localparam logic [31:0] FEC_ONES_MASK  = 32'h80000000;   // fixed ones, fec format

    // header encodings, bit [0] is sent first
    localparam logic [0:1]  SH_ONE         = 2'b01;          // carries stream bit 1
    localparam logic [0:1]  SH_ZERO        = 2'b10;          // carries stream bit 0

    // reset values
    localparam logic [7:0]  MB_IDX_RESET   = 8'h00;          // extended multiblock position

    // one transmitted 66-bit block
    typedef struct packed {
        logic [0:1]  sh;                                     // sync header, [0] first
        logic [63:0] payload;                                // scrambled payload, bit 0 first
    } blk_s;

endpackage : sh_stream_pkg

//--- core/sync_header_stream_crc12.sv
// sync header framer: crc-12 parity and stream word insertion for 64b/66b blocks
`timescale 1ns/10ps
// Functional notes
// RL1 - headers always complementary, 01 or 10
// RL2 - receiver locks on periodic header transitions
// RL3 - receiver restarts search after bad headers
// RL4 - header 01 sends one, 10 sends zero
// RL5 - one stream bit per block, 32 bits
// RL6 - only crc-12 and fec formats offered
// RL7 - stream ends in pilot 00001
// RL8 - receiver confirms fec boundary over multiblocks
// RL9 - bit 22 marks last extended multiblock
// RL10 - parity of multiblock sent in next
// RL11 - receiver compares parity, flags mismatch
// RL12 - first bit error seen after 46 blocks
// RL13 - format code 0 selects crc-12
// RL14 - crc-12 stream bit placement
// RL15 - command bits always zero
// RL16 - parity polynomial 0x987
// RL17 - parity covers 2048 payload bits only
// RL18 - parity stages cleared each multiblock
// RL19 - receiver may align after one multiblock
// RL20 - scrambled payload plus header forms block
// RL21 - format code 2 selects fec
// RL22 - bits fed in order, latched per multiblock
module sync_header_stream_crc12 #(
    parameter int unsigned MB_PER_EMB = 1                // multiblocks per extended multiblock
) (
    // clock and reset
    input  wire logic                      clk_sys,
    input  wire logic                      rst_n,
    // payload side
    input  wire logic                      blkValid,     // one scrambled block this cycle
    input  wire logic [63:0]               blkPayload,   // scrambled bits, bit 0 first
    input  wire logic [25:0]               fecParity,    // parity from fec generator
    input  wire logic [1:0]                header_stream_format_select,
    // line side
    output logic                           txValid,      // block on txBlock
    output sh_stream_pkg::blk_s            txBlock,      // 66-bit block
    output logic [4:0]                     txBlockIdx,   // block index in multiblock
    output logic                           multiblock_end_pilot,          // last block sent
    output logic                           extended_multiblock_end_flag,  // stream bit 22
    output logic                           formatUnsupported,             // code not 0 or 2
    output logic [11:0]                    crcWord       // parity of previous multiblock, updated at each multiblock start in either format
);

    // advance the parity register over one block, first payload bit first
    function automatic logic [11:0] crcStep(input logic [11:0] s, input logic [63:0] d);
        logic [11:0] r;
        logic [11:0] mask;
        logic        fb;
        r    = s;
        mask = {sh_stream_pkg::CRC_POLY[10:0], 1'b1};    // see RL16
        fb   = 1'b0;
        for (int i = 0; i < 64; i++)
        begin
            fb = d[i] ^ r[11];                           // see RL22
            r  = {r[10:0], 1'b0} ^ (fb ? mask : 12'h000);
        end
        return r;
    endfunction : crcStep

    // lay out one stream word for the selected format
    function automatic logic [31:0] buildStream(input sh_stream_pkg::format_e f,
                                                input logic [11:0] c,
                                                input logic [25:0] p,
                                                input logic        embEnd);
        logic [31:0] w;
        w = 32'h00000000;
        if (f == sh_stream_pkg::FMT_FEC)
        begin
            // fec word high bits first, bit 22 left for the flag
            w = sh_stream_pkg::FEC_ONES_MASK;
            for (int i = 0; i < 22; i++)
            begin
                w[i] = p[25 - i];
            end
            for (int i = 0; i < 4; i++)
            begin
                w[23 + i] = p[3 - i];
            end
        end
        else
        begin
            // crc bits in groups of three, each closed by a one
            w = sh_stream_pkg::CRC_ONES_MASK;            // see RL14
            for (int g = 0; g < 4; g++)
            begin
                for (int k = 0; k < 3; k++)
                begin
                    w[4 * g + k] = c[11 - 3 * g - k];    // see RL14
                end
            end
            // command positions stay at zero from the initial value, see RL15
        end
        w[sh_stream_pkg::EMB_END_POS] = embEnd;          // see RL9
        return w;
    endfunction : buildStream

    // position and parity state
    logic [4:0]              blockIdx;                   // next block's index
    logic [7:0]              mbIdx;                      // multiblock within extended one
    logic [11:0]             crcState;                   // running parity stages
    logic [11:0]             crcLatched;                 // finished parity of last multiblock
    logic [31:0]             streamWord;                 // stream of current multiblock
    logic [4:0]              next_blockIdx;
    logic [7:0]              next_mbIdx;
    logic [11:0]             next_crcState;
    logic [11:0]             next_crcLatched;
    logic [31:0]             next_streamWord;
    logic                    lineCrcFmt;                 // multiblock on line is crc-12
    logic                    next_lineCrcFmt;

    // output state
    logic                    next_txValid;
    sh_stream_pkg::blk_s     next_txBlock;
    logic [4:0]              next_txBlockIdx;
    logic                    next_pilot;
    logic                    next_embEndFlag;
    logic                    next_unsupported;
    logic [11:0]             next_crcWord;

    // decoded format, unknown codes fall back to crc-12
    sh_stream_pkg::format_e  fmtSel;
    logic                    fmtBad;
    logic                    lastMb;                     // current is last of extended
    logic [31:0]             curWord;                    // stream word used this block
    logic                    curBit;                     // stream bit carried now

    // format decode, only two codes are implemented
    always_comb
    begin
        fmtSel = sh_stream_pkg::FMT_CRC12;               // see RL13
        fmtBad = 1'b0;
        case (header_stream_format_select)
            2'b00:   fmtSel = sh_stream_pkg::FMT_CRC12;  // see RL13
            2'b10:   fmtSel = sh_stream_pkg::FMT_FEC;    // see RL21
            default:
            begin
                // no crc-3 or command channel; crc-12 keeps the link framed
                fmtSel = sh_stream_pkg::FMT_CRC12;       // see RL6
                fmtBad = 1'b1;
            end
        endcase
    end

    // next state of position, parity and stream word
    always_comb
    begin
        next_blockIdx   = blockIdx;
        next_mbIdx      = mbIdx;
        next_crcState   = crcState;
        next_crcLatched = crcLatched;
        next_streamWord = streamWord;
        next_lineCrcFmt = lineCrcFmt;
        lastMb          = (32'(mbIdx) == MB_PER_EMB - 1);
        // format and flag are sampled only at a multiblock start, so a
        // change of select never splits one stream word
        if (blockIdx == sh_stream_pkg::FIRST_BLOCK)
        begin
            curWord = buildStream(fmtSel, crcLatched, fecParity, lastMb);  // see RL10
        end
        else
        begin
            curWord = streamWord;
        end
        curBit = curWord[blockIdx];                      // see RL5
        if (blkValid)
        begin
            next_blockIdx   = blockIdx + 5'h01;
            next_streamWord = curWord;
            // format is latched with the word, so checks never guess it from data bits
            if (blockIdx == sh_stream_pkg::FIRST_BLOCK)
            begin
                next_lineCrcFmt = (fmtSel == sh_stream_pkg::FMT_CRC12);
            end
            if (blockIdx == sh_stream_pkg::LAST_BLOCK)
            begin
                // whole multiblock done: keep parity for the next one
                next_crcLatched = crcStep(crcState, blkPayload);   // see RL12
                next_crcState   = sh_stream_pkg::CRC_RESET;        // see RL18
                next_mbIdx      = lastMb ? sh_stream_pkg::MB_IDX_RESET : mbIdx + 8'h01;
            end
            else
            begin
                // payload only, headers never enter the parity
                next_crcState = crcStep(crcState, blkPayload);     // see RL17
            end
        end
    end

    // next values of the registered outputs
    always_comb
    begin
        next_txValid         = blkValid;
        next_txBlock         = txBlock;
        next_txBlockIdx      = txBlockIdx;
        next_pilot           = 1'b0;
        next_embEndFlag      = extended_multiblock_end_flag;
        next_unsupported     = fmtBad;
        next_crcWord         = crcWord;
        if (blkValid)
        begin
            next_txBlock.payload = blkPayload;           // see RL20
            next_txBlock.sh      = curBit ? sh_stream_pkg::SH_ONE
                                          : sh_stream_pkg::SH_ZERO;  // see RL1
            next_txBlockIdx      = blockIdx;
            next_pilot           = (blockIdx == sh_stream_pkg::LAST_BLOCK);  // see RL7
            next_embEndFlag      = curWord[sh_stream_pkg::EMB_END_POS];
            if (blockIdx == sh_stream_pkg::FIRST_BLOCK)
            begin
                next_crcWord = crcLatched;
            end
        end
    end

    // register every group; blocks gap freely, state holds between them
    always_ff @(posedge clk_sys or negedge rst_n)
    begin
        if (!rst_n)
        begin
            blockIdx                     <= sh_stream_pkg::FIRST_BLOCK;
            mbIdx                        <= sh_stream_pkg::MB_IDX_RESET;
            crcState                     <= sh_stream_pkg::CRC_RESET;
            crcLatched                   <= sh_stream_pkg::CRC_RESET;
            streamWord                   <= 32'h00000000;
            lineCrcFmt                   <= 1'b1;
            txValid                      <= 1'b0;
            txBlock                      <= '0;
            txBlockIdx                   <= sh_stream_pkg::FIRST_BLOCK;
            multiblock_end_pilot         <= 1'b0;
            extended_multiblock_end_flag <= 1'b0;
            formatUnsupported            <= 1'b0;
            crcWord                      <= sh_stream_pkg::CRC_RESET;
        end
        else
        begin
            blockIdx                     <= next_blockIdx;
            mbIdx                        <= next_mbIdx;
            crcState                     <= next_crcState;
            crcLatched                   <= next_crcLatched;
            streamWord                   <= next_streamWord;
            lineCrcFmt                   <= next_lineCrcFmt;
            txValid                      <= next_txValid;
            txBlock                      <= next_txBlock;
            txBlockIdx                   <= next_txBlockIdx;
            multiblock_end_pilot         <= next_pilot;
            extended_multiblock_end_flag <= next_embEndFlag;
            formatUnsupported            <= next_unsupported;
            crcWord                      <= next_crcWord;
        end
    end

    // helper: crc format of the multiblock now on the line
    logic outCrcFmt;
    assign outCrcFmt = lineCrcFmt;

    // a final block seen on the input side
    sequence lastBlockIn;
        blkValid && (blockIdx == sh_stream_pkg::LAST_BLOCK);
    endsequence

    // a first block of a crc-12 multiblock
    sequence firstCrcBlockIn;
        blkValid && (blockIdx == sh_stream_pkg::FIRST_BLOCK) && (fmtSel == sh_stream_pkg::FMT_CRC12);
    endsequence

    a_sh_complement: assert property (@(posedge clk_sys) disable iff (!rst_n) // see RL1
        txValid |-> (txBlock.sh[0] != txBlock.sh[1]))
        else $error("sync header bits not complementary");

    a_header_bit_map: assert property (@(posedge clk_sys) disable iff (!rst_n) // see RL4
        blkValid |=> (txBlock.sh == (streamWord[txBlockIdx] ? 2'b01 : 2'b10)))
        else $error("header does not match stream bit");

    a_crc_stage_clear: assert property (@(posedge clk_sys) disable iff (!rst_n) // see RL18
        lastBlockIn |=> (crcState == 12'h000) && (txBlockIdx == 5'h1f))
        else $error("parity stages not cleared after multiblock");

    a_parity_carried: assert property (@(posedge clk_sys) disable iff (!rst_n) // see RL10
        lastBlockIn ##[1:8] firstCrcBlockIn |=> (crcWord == crcLatched)
            && (streamWord[2:0] == {crcLatched[9], crcLatched[10], crcLatched[11]}))
        else $error("parity of previous multiblock not carried");

    a_pilot_tail: assert property (@(posedge clk_sys) disable iff (!rst_n) // see RL7
        (txValid && txBlockIdx >= 5'h1b) |->
            (txBlock.sh == ((txBlockIdx == 5'h1f) ? 2'b01 : 2'b10)))
        else $error("end pilot 00001 missing");

    a_emb_end_flag: assert property (@(posedge clk_sys) disable iff (!rst_n) // see RL9
        (blkValid && blockIdx == 5'h00) |=>
            (extended_multiblock_end_flag == (32'(mbIdx) == MB_PER_EMB - 1)))
        else $error("extended multiblock flag wrong");

    a_crc_fixed_ones: assert property (@(posedge clk_sys) disable iff (!rst_n) // see RL14
        (txValid && outCrcFmt) |->
            ((streamWord & 32'h80a88888) == 32'h80a88888) && (streamWord[30:27] == 4'h0))
        else $error("fixed ones or zeros misplaced");

    a_cmd_zero: assert property (@(posedge clk_sys) disable iff (!rst_n) // see RL15
        (txValid && outCrcFmt) |->
            (streamWord[18:16] == 3'h0) && !streamWord[20] && (streamWord[26:24] == 3'h0))
        else $error("command bits not zero");

    a_bad_format: assert property (@(posedge clk_sys) disable iff (!rst_n) // see RL6
        (header_stream_format_select[0] == 1'b1) |=> formatUnsupported)
        else $error("unsupported format not flagged");

endmodule : sync_header_stream_crc12

//--- verif/sh_rx_model.sv
// receiver-side partner model: header checks, stream word rebuild, crc-12 compare
`timescale 1ns/10ps
module sh_rx_model (
    // clock and reset
    input  wire logic                clk_sys,
    input  wire logic                rst_n,
    // line side
    input  wire logic                rxValid,     // block arriving this cycle
    input  wire sh_stream_pkg::blk_s rxBlock,     // header plus scrambled payload
    input  wire logic                crcMode,     // receiver configured for crc-12
    // results
    output logic [31:0]              streamWord,  // last complete stream word
    output logic [11:0]              mbCrc,       // own parity of last complete mb
    output logic [7:0]               nCrcErr,     // carried parity mismatches
    output logic [7:0]               nHdrErr,     // headers of 00 or 11
    output logic [7:0]               nPilotErr    // stream words without end pilot
);
    logic [4:0]  blkCnt;   // block position, aligned from reset
    logic [31:0] acc;      // stream bits gathered so far
    logic [11:0] crc;      // running parity
    logic [11:0] prevCrc;  // parity of previous mb, zero after reset

    // one galois step; taps x^9 x^8 x^3 x^2 x 1, the x^12 term is implicit
    function automatic logic [11:0] step(input logic [11:0] c, input logic d);
        return {c[10:0], 1'b0} ^ ((c[11] ^ d) ? 12'h30f : 12'h000);
    endfunction : step

    // behavioural receiver; it trusts reset for alignment, as a real one would after lock
    always @(posedge clk_sys or negedge rst_n)
    begin : rx
        logic [11:0] c;
        logic [31:0] w;
        logic [11:0] got;
        if (!rst_n)
        begin
            blkCnt = 5'h00;
            acc = 32'h0;
            crc = 12'h000;
            prevCrc = 12'h000;
            streamWord = 32'h0;
            mbCrc = 12'h000;
            nCrcErr = 8'h00;
            nHdrErr = 8'h00;
            nPilotErr = 8'h00;
        end
        else if (rxValid)
        begin
            if (rxBlock.sh[0] === rxBlock.sh[1])
                nHdrErr++;
            w = acc;
            w[blkCnt] = (rxBlock.sh === sh_stream_pkg::SH_ONE);
            // stages start from zero on the first block of each mb
            c = (blkCnt == 5'h00) ? 12'h000 : crc;
            for (int i = 0; i < 64; i++)
                c = step(c, rxBlock.payload[i]);
            if (blkCnt == 5'h1f)
            begin
                // alignment after one mb is safe only because the pilot is unique
                if (w[31:27] !== 5'h10)
                    nPilotErr++;
                got = {w[0], w[1], w[2], w[4], w[5], w[6],
                       w[8], w[9], w[10], w[12], w[13], w[14]};
                if (crcMode && got !== prevCrc)
                    nCrcErr++;
                streamWord = w;
                mbCrc = c;
                prevCrc = c;
            end
            acc = w;
            crc = c;
            blkCnt++;
        end
    end
endmodule : sh_rx_model

//--- verif/sync_header_stream_crc12_tb_top.sv
// testbench: crc-12 parity chain, fec word layout and format fallback
`timescale 1ns/10ps
module sync_header_stream_crc12_tb_top;
    localparam int unsigned EMB = 2;   // two mbs per extended mb, so bit 22 toggles
    // stimulus
    logic                clk_sys = 1'b0;
    logic                rst_n = 1'b0;
    logic                blkValid = 1'b0;
    logic [63:0]         blkPayload = 64'h0;
    logic [25:0]         fecParity = 26'h0;
    logic [1:0]          fmt = 2'h0;
    // design outputs
    logic                txValid;
    sh_stream_pkg::blk_s txBlock;
    logic [4:0]          txBlockIdx;
    logic                pilot;
    logic                embEnd;
    logic                unsup;
    logic [11:0]         crcWord;
    // partner results
    logic [31:0]         streamWord;
    logic [11:0]         mbCrc;
    logic [7:0]          nCrcErr;
    logic [7:0]          nHdrErr;
    logic [7:0]          nPilotErr;
    int                  n_errors = 0;
    int                  comparisons = 0;
    int                  pilots = 0;

    always #10 clk_sys = ~clk_sys;

    sync_header_stream_crc12 #(.MB_PER_EMB(EMB)) u_sync_header_stream_crc12 (
        .clk_sys(clk_sys), .rst_n(rst_n), .blkValid(blkValid), .blkPayload(blkPayload),
        .fecParity(fecParity), .header_stream_format_select(fmt), .txValid(txValid),
        .txBlock(txBlock), .txBlockIdx(txBlockIdx), .multiblock_end_pilot(pilot),
        .extended_multiblock_end_flag(embEnd), .formatUnsupported(unsup), .crcWord(crcWord));

    sh_rx_model u_sh_rx_model (
        .clk_sys(clk_sys), .rst_n(rst_n), .rxValid(txValid), .rxBlock(txBlock),
        .crcMode(fmt != 2'h2), .streamWord(streamWord), .mbCrc(mbCrc),
        .nCrcErr(nCrcErr), .nHdrErr(nHdrErr), .nPilotErr(nPilotErr));

    // pilot pulses that coincide with the last block
    always @(posedge clk_sys)
        if (pilot === 1'b1 && txBlockIdx === 5'h1f)
            pilots++;

    task automatic check(input logic [31:0] got, input logic [31:0] exp);
        comparisons++;
        if (got !== exp)
        begin
            n_errors++;
            $display("unexpected at %0t: got %h expected %h", $time, got, exp);
        end
    endtask : check

    // crc layout: ones at 3 7 11 15 19 21 23 31, command bits left zero
    function automatic logic [31:0] crcExp(input logic [11:0] c, input logic e);
        logic [31:0] w;
        w = 32'h80a88888;
        {w[0], w[1], w[2], w[4], w[5], w[6], w[8], w[9], w[10], w[12], w[13], w[14]} = c;
        w[22] = e;
        return w;
    endfunction : crcExp

    // fec layout: word msb first in bits 0-21 and 23-26
    function automatic logic [31:0] fecExp(input logic [25:0] f, input logic e);
        logic [31:0] w;
        w = 32'h80000000;
        for (int i = 0; i < 22; i++)
            w[i] = f[25 - i];
        for (int i = 23; i < 27; i++)
            w[i] = f[26 - i];
        w[22] = e;
        return w;
    endfunction : fecExp

    task automatic do_reset();
        @(posedge clk_sys);
        rst_n <= 1'b0;
        repeat (4) @(posedge clk_sys);
        rst_n <= 1'b1;
    endtask : do_reset

    // one multiblock; gaps put an idle cycle after every odd block
    task automatic send_mb(input int m, input bit gaps);
        for (int b = 0; b < 32; b++)
        begin
            @(posedge clk_sys);
            blkValid <= 1'b1;
            blkPayload <= {2{32'h9e3779b9 * 32'(m * 32 + b + 1)}};
            if (gaps && b[0])
            begin
                @(posedge clk_sys);
                blkValid <= 1'b0;
                blkPayload <= ~blkPayload;
            end
        end
        @(posedge clk_sys);
        blkValid <= 1'b0;
        blkPayload <= ~blkPayload;  // idle payload inverts the last block, or repeats it when gaps is set
        repeat (3) @(posedge clk_sys);
    endtask : send_mb

    // three chained mbs; the parity of each must ride in the next
    task automatic scen_crc_chain();
        logic [11:0] prev;
        prev = 12'h000;
        do_reset();
        fmt <= 2'h0;
        pilots = 0;
        for (int m = 0; m < 3; m++)
        begin
            send_mb(m, m == 1);
            check(streamWord, crcExp(prev, (m % EMB) == EMB - 1));
            check({20'h0, crcWord}, {20'h0, prev});
            check({31'h0, embEnd}, {31'h0, (m % EMB) == EMB - 1});
            prev = mbCrc;
        end
        check({24'h0, nCrcErr}, 32'h0);
        check({24'h0, nHdrErr}, 32'h0);
        check({24'h0, nPilotErr}, 32'h0);
        check(32'(pilots), 32'h3);
    endtask : scen_crc_chain

    task automatic scen_fec();
        do_reset();
        fmt <= 2'h2;
        fecParity <= 26'h2b4c1d7;
        send_mb(5, 1'b0);
        check(streamWord, fecExp(26'h2b4c1d7, 1'b0));
        check({31'h0, unsup}, 32'h0);
    endtask : scen_fec

    // codes 1 and 3 are not offered and must fall back to crc-12
    task automatic scen_fallback();
        logic [11:0] prev;
        prev = 12'h000;
        do_reset();
        for (int k = 0; k < 2; k++)
        begin
            fmt <= (k == 0) ? 2'h1 : 2'h3;
            send_mb(7 + k, 1'b0);
            check({31'h0, unsup}, 32'h1);
            check(streamWord, crcExp(prev, k == 1));
            prev = mbCrc;
        end
        check({24'h0, nCrcErr}, 32'h0);
    endtask : scen_fallback

    task automatic close_out();
        $display("errors %0d comparisons %0d", n_errors, comparisons);
        if (n_errors == 0 && comparisons > 0)
            $display("== PASSED ==");
        else
            $display("== FAILED ==");
        $finish;
    endtask : close_out

    // watchdog: roughly twenty times the length of all scenarios
    initial
    begin
        #100000;
        n_errors++;
        close_out();
    end

    initial
    begin
        repeat (4) @(posedge clk_sys);
        scen_crc_chain();
        scen_fec();
        scen_fallback();
        close_out();
    end
endmodule : sync_header_stream_crc12_tb_top
